// ---- rtl/vfp_cfg.svh ----
// constants of the regulator fault protection block: offsets, fields, resets, timing
// assumes a 25 MHz system clock and a 32-bit classic wishbone register bus
`ifndef VFP_CFG_SVH
`define VFP_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define VFP_ADDR_CTRL 8'h00
`define VFP_ADDR_STATUS 8'h04
`define VFP_ADDR_IRQ_STAT 8'h08
`define VFP_ADDR_IRQ_MASK 8'h0C
`define VFP_ADDR_TARGET 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define VFP_CTRL_PWM_EN 0
`define VFP_CTRL_FORCE_LOW_SIDE 1
`define VFP_IRQ_OVER 0
`define VFP_IRQ_REV 1
`define VFP_IRQ_THERM 2
`define VFP_IRQ_SHDN 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define VFP_CTRL_RST 2'h1
`define VFP_IRQ_MASK_RST 4'h0
`define VFP_CODE_RST 7'h00

// ----------------------------------------
// voltage code arithmetic, target in units of 0.1 mV
// ----------------------------------------
`define VFP_TARGET_TOP 14'h3A98
`define VFP_TARGET_STEP 14'h007D
`define VFP_CODE_ZERO_FROM 7'h78

// ----------------------------------------
// timing
// ----------------------------------------
`define VFP_CLK_NS 40
`define VFP_KEEPOUT_NS 400
`define VFP_KEEPOUT_CYC ((`VFP_KEEPOUT_NS + `VFP_CLK_NS - 1) / `VFP_CLK_NS)

`endif

// ---- rtl/vfp_pkg.sv ----
// types shared by the regulator fault protection block
// assumes vfp_cfg.svh is compiled alongside; holds no logic
package vfp_pkg;

  // ----------------------------------------
  // protection state, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    VFP_ST_OFF = 4'b0001,
    VFP_ST_RUN = 4'b0010,
    VFP_ST_REV = 4'b0100,
    VFP_ST_LATCH = 4'b1000
  } vfp_state_type;

  // ----------------------------------------
  // comparator and pin flags after synchronising
  // ----------------------------------------
  typedef struct packed {
    logic ov;
    logic rv_enter;
    logic rv_exit;
    logic th_trip;
    logic th_release;
    logic lockout;
    logic enable;
    logic [6:0] code;
  } vfp_flags_type;

  // ----------------------------------------
  // driver-facing outputs
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] pwm;
    logic low_side_mode_n;
    logic driver_enable_n;
    logic discharge;
  } vfp_drive_type;

endpackage

// ---- rtl/vfp_sync.sv ----
// two-flop synchroniser for a bundle of independent asynchronous levels
// assumes each bit is a slow level; multi-bit words need their own settling check
`timescale 1ns/100ps
`default_nettype none
module vfp_sync #(
  parameter int W = 14
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ----------------------------------------
  // first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

// ---- rtl/vfp_vcode.sv ----
// decoder from 7-bit voltage code to target level in 0.1 mV units
// assumes a settled code; purely combinational
`include "vfp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module vfp_vcode (
  input wire logic [6:0] code,
  output logic [13:0] target_dmv
);

  // top level minus one step per code, floor at zero
  function automatic logic [13:0] vfp_decode(input logic [6:0] c);
    logic [13:0] drop;
    drop = 14'({7'h00, c} * `VFP_TARGET_STEP);
    if (c >= `VFP_CODE_ZERO_FROM) begin
      vfp_decode = 14'h0000;
    end else begin
      vfp_decode = `VFP_TARGET_TOP - drop;
    end
  endfunction

  // ----------------------------------------
  // msb-first code, all zeros is the top level
  // ----------------------------------------
  assign target_dmv = vfp_decode(code);

endmodule
`default_nettype wire

// ---- rtl/vfp_top.sv ----
// protection and mode control of a multiphase buck controller, with wishbone registers
// assumes comparator flags and pins are asynchronous levels, pwm requests on clk_sys
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`include "vfp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module vfp_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic overvoltage_trip,
  input wire logic reverse_voltage_trip,
  input wire logic reverse_voltage_clear,
  input wire logic thermal_sense_in,
  input wire logic thermal_sense_release,
  input wire logic supply_lockout,
  input wire logic enable_in,
  input wire logic [6:0] voltage_code,
  input wire logic [2:0] pwm_req,
  output logic [2:0] pwm_out,
  output logic low_side_mode_n,
  output logic driver_enable_n,
  output logic soft_start_discharge,
  output logic power_good_delay_cap,
  output logic thermal_alert_out,
  output logic [13:0] target_dmv
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  vfp_pkg::vfp_flags_type flags_raw;
  vfp_pkg::vfp_flags_type flags;
  logic [13:0] flags_bits;

  // the input system keeps pins low around supply ramps, so zero reset is safe
  assign flags_raw = '{
    ov: overvoltage_trip,
    rv_enter: reverse_voltage_trip,
    rv_exit: reverse_voltage_clear,
    th_trip: thermal_sense_in,
    th_release: thermal_sense_release,
    lockout: supply_lockout,
    enable: enable_in,
    code: voltage_code
  };

  vfp_sync #(.W(14)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in(flags_raw),
    .sync_out(flags_bits)
  );

  assign flags = vfp_pkg::vfp_flags_type'(flags_bits);

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  vfp_pkg::vfp_state_type state_r;
  vfp_pkg::vfp_state_type state_nxt;
  vfp_pkg::vfp_drive_type drive_nxt;
  logic rv_active_r;
  logic rv_active_nxt;
  logic therm_r;
  logic therm_nxt;
  logic [1:0] ctrl_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic [6:0] code_r;
  logic [6:0] code_prev_r;
  logic [3:0] keep_cnt_r;
  logic [13:0] target_nxt;
  logic [2:0] pwm_r;
  logic ls_r;
  logic de_r;
  logic dis_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic irq_r;

  // ----------------------------------------
  // supply and enable qualification
  // ----------------------------------------
  // no start-up timer here: the synchronised pins alone decide when shutdown ends
  wire power_ok = flags.enable & ~flags.lockout;

  // ----------------------------------------
  // reverse voltage watch with hysteresis, runs in every state
  // ----------------------------------------
  // entry below -300 mV wins if both flags are seen at once
  // the watch flop has no state gate, so it keeps running through latch-off
  assign rv_active_nxt = flags.rv_enter ? 1'b1 :
                         (flags.rv_exit ? 1'b0 : rv_active_r);

  // ----------------------------------------
  // thermal alert with hysteresis
  // ----------------------------------------
  // the two comparator levels sit about 100 mV apart, so the alert cannot chatter
  assign therm_nxt = flags.th_trip ? 1'b1 :
                     (flags.th_release ? 1'b0 : therm_r);

  // ----------------------------------------
  // protection state transitions
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      vfp_pkg::VFP_ST_OFF: begin
        if (power_ok) begin
          state_nxt = vfp_pkg::VFP_ST_RUN;
        end
      end
      vfp_pkg::VFP_ST_RUN: begin
        if (!power_ok) begin
          state_nxt = vfp_pkg::VFP_ST_OFF;
        end else if (flags.ov) begin
          state_nxt = vfp_pkg::VFP_ST_LATCH;
        end else if (rv_active_nxt) begin
          state_nxt = vfp_pkg::VFP_ST_REV;
        end
      end
      vfp_pkg::VFP_ST_REV: begin
        if (!power_ok) begin
          state_nxt = vfp_pkg::VFP_ST_OFF;
        end else if (flags.ov) begin
          state_nxt = vfp_pkg::VFP_ST_LATCH;
        end else if (!rv_active_nxt) begin
          state_nxt = vfp_pkg::VFP_ST_RUN;
        end
      end
      vfp_pkg::VFP_ST_LATCH: begin
        // only supply loss or enable low releases the latch
        if (!power_ok) begin
          state_nxt = vfp_pkg::VFP_ST_OFF;
        end
      end
      default: begin
        state_nxt = vfp_pkg::VFP_ST_OFF;
      end
    endcase
  end

  // ----------------------------------------
  // driver line selection per state
  // ----------------------------------------
  always_comb begin
    drive_nxt = '{pwm: 3'h0, low_side_mode_n: 1'b0, driver_enable_n: 1'b0, discharge: 1'b0};
    unique case (state_nxt)
      vfp_pkg::VFP_ST_OFF: begin
        drive_nxt.discharge = 1'b1;
      end
      vfp_pkg::VFP_ST_RUN: begin
        drive_nxt.pwm = ctrl_r[`VFP_CTRL_PWM_EN] ? pwm_req : 3'h0;
        drive_nxt.low_side_mode_n = ~ctrl_r[`VFP_CTRL_FORCE_LOW_SIDE];
        drive_nxt.driver_enable_n = 1'b1;
      end
      vfp_pkg::VFP_ST_REV: begin
        drive_nxt.pwm = 3'h0;
      end
      vfp_pkg::VFP_ST_LATCH: begin
        // crowbar, unless the output has gone negative
        drive_nxt.low_side_mode_n = ~rv_active_nxt;
        drive_nxt.driver_enable_n = ~rv_active_nxt;
      end
      default: begin
        drive_nxt.discharge = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // state and output flops
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= vfp_pkg::VFP_ST_OFF;
      rv_active_r <= 1'b0;
      therm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rv_active_r <= rv_active_nxt;
      therm_r <= therm_nxt;
    end
  end

  // outputs registered so the drivers never see decode glitches
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwm_r <= 3'h0;
      ls_r <= 1'b0;
      de_r <= 1'b0;
      dis_r <= 1'b1;
    end else begin
      pwm_r <= drive_nxt.pwm;
      ls_r <= drive_nxt.low_side_mode_n;
      de_r <= drive_nxt.driver_enable_n;
      dis_r <= drive_nxt.discharge;
    end
  end

  // ----------------------------------------
  // voltage code keep-out and decode
  // ----------------------------------------
  // bits are synchronised separately, so a code is taken only once it stops moving
  // a code that flips back inside the keep-out is never taken, by intent
  wire code_moved = flags.code != code_prev_r;
  wire keep_done = keep_cnt_r == 4'(`VFP_KEEPOUT_CYC);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      code_prev_r <= `VFP_CODE_RST;
      keep_cnt_r <= 4'h0;
      code_r <= `VFP_CODE_RST;
    end else begin
      code_prev_r <= flags.code;
      if (code_moved) begin
        keep_cnt_r <= 4'h0;
      end else if (!keep_done) begin
        keep_cnt_r <= keep_cnt_r + 4'h1;
      end else begin
        code_r <= code_prev_r;
      end
    end
  end

  vfp_vcode u_vcode (
    .code(code_r),
    .target_dmv(target_nxt)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      target_dmv <= `VFP_TARGET_TOP;
    end else begin
      target_dmv <= target_nxt;
    end
  end

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  // one rising-edge helper for every source, so all four events share one timing
  function automatic logic vfp_rise(input logic now_v, input logic was_v);
    vfp_rise = now_v & ~was_v;
  endfunction

  wire ev_over = vfp_rise(state_nxt[3], state_r[3]);
  wire ev_rev = vfp_rise(rv_active_nxt, rv_active_r);
  wire ev_therm = vfp_rise(therm_nxt, therm_r);
  wire ev_shdn = vfp_rise(state_nxt[0], state_r[0]);
  wire [3:0] ev_vec = {ev_shdn, ev_therm, ev_rev, ev_over};

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  // full byte compare, so no register answers at an alias
  function automatic logic vfp_hit(input logic [7:0] adr, input logic [7:0] off);
    vfp_hit = adr == off;
  endfunction

  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = vfp_hit(wb_adr_i, `VFP_ADDR_CTRL);
  wire hit_status = vfp_hit(wb_adr_i, `VFP_ADDR_STATUS);
  wire hit_istat = vfp_hit(wb_adr_i, `VFP_ADDR_IRQ_STAT);
  wire hit_imask = vfp_hit(wb_adr_i, `VFP_ADDR_IRQ_MASK);
  wire hit_target = vfp_hit(wb_adr_i, `VFP_ADDR_TARGET);
  wire [3:0] w1c = (bus_wr & hit_istat) ? wb_dat_i[3:0] : 4'h0;
  wire [3:0] istat_nxt = (irq_stat_r & ~w1c) | ev_vec;
  wire [31:0] status_word = {21'h000000, flags.lockout, flags.enable,
                             therm_r, rv_active_r, 3'h0, state_r};
  wire [31:0] rdata_nxt = hit_ctrl ? {30'h00000000, ctrl_r} :
                          hit_status ? status_word :
                          hit_istat ? {28'h0000000, irq_stat_r} :
                          hit_imask ? {28'h0000000, irq_mask_r} :
                          hit_target ? {9'h000, code_r, 2'h0, target_dmv} :
                          32'h00000000;

  // ----------------------------------------
  // register writes; a new event beats a clear in the same cycle
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `VFP_CTRL_RST;
      irq_mask_r <= `VFP_IRQ_MASK_RST;
      irq_stat_r <= 4'h0;
    end else begin
      if (bus_wr && hit_ctrl) begin
        ctrl_r <= wb_dat_i[1:0];
      end
      if (bus_wr && hit_imask) begin
        irq_mask_r <= wb_dat_i[3:0];
      end
      irq_stat_r <= istat_nxt;
    end
  end

  // ack one cycle after the request; unmapped reads return zero
  // read data is zero outside ack, so a stale word never shows between accesses
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      irq_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
      rdata_r <= bus_req ? rdata_nxt : 32'h00000000;
      irq_r <= |(istat_nxt & irq_mask_r);
    end
  end

  // ----------------------------------------
  // output mapping
  // ----------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign irq_o = irq_r;
  assign pwm_out = pwm_r;
  assign low_side_mode_n = ls_r;
  assign driver_enable_n = de_r;
  assign soft_start_discharge = dis_r;
  assign power_good_delay_cap = dis_r;
  assign thermal_alert_out = therm_r;

endmodule
`default_nettype wire

// ---- test/vfp_props.sv ----
// checker of the protection block, watching the top ports only
// assumes one clock, reset asynchronous and active low
`timescale 1ns/100ps
`default_nettype none
module vfp_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic overvoltage_trip,
  input wire logic reverse_voltage_trip,
  input wire logic reverse_voltage_clear,
  input wire logic thermal_sense_in,
  input wire logic thermal_sense_release,
  input wire logic supply_lockout,
  input wire logic enable_in,
  input wire logic [6:0] voltage_code,
  input wire logic [2:0] pwm_out,
  input wire logic low_side_mode_n,
  input wire logic driver_enable_n,
  input wire logic soft_start_discharge,
  input wire logic power_good_delay_cap,
  input wire logic thermal_alert_out,
  input wire logic [13:0] target_dmv
);
  // ----
  // code settling helper
  // ----
  logic [6:0] code_r;
  logic [4:0] still_r;
  wire logic [13:0] exp_dmv;
  wire logic off_out;
  wire logic dis_out;
  assign exp_dmv = (code_r >= 7'h78) ? 14'h0000 : 14'h3A98 - 14'h007D * {7'h00, code_r};
  assign off_out = pwm_out == 3'h0 && !low_side_mode_n && !driver_enable_n;
  assign dis_out = soft_start_discharge && power_good_delay_cap;
  // how long the code sat still; a skewed change restarts the count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      code_r <= 7'h00;
      still_r <= 5'h00;
    end else begin
      code_r <= voltage_code;
      still_r <= (voltage_code != code_r) ? 5'h00 : still_r + {4'h0, still_r != 5'h1F};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_enable_low_off: assert property (
    (!enable_in)[*6] |-> off_out && dis_out) else $error("not shut down, enable low");
  a_lockout_off: assert property (
    supply_lockout[*6] |-> off_out && dis_out) else $error("not shut down in lockout");
  a_ov_pwm_low: assert property (
    (overvoltage_trip && enable_in && !supply_lockout && !reverse_voltage_trip)[*8]
    |-> pwm_out == 3'h0) else $error("pwm active during overvoltage");
  a_rev_all_off: assert property (
    reverse_voltage_trip[*5] |-> off_out) else $error("switches on in reverse");
  a_rev_hold: assert property (
    (reverse_voltage_trip && !overvoltage_trip) ##1
    (!reverse_voltage_clear && !overvoltage_trip)[*6] |-> off_out)
    else $error("reverse left before clear");
  a_alert_set: assert property (
    (thermal_sense_in && !thermal_sense_release)[*5] |-> thermal_alert_out)
    else $error("alert missing");
  a_alert_clr: assert property (
    (thermal_sense_release && !thermal_sense_in)[*5] |-> !thermal_alert_out)
    else $error("alert stuck");
  a_sync_delay: assert property (
    (!thermal_sense_in && !thermal_alert_out)[*3] ##1 thermal_sense_in
    |-> !thermal_alert_out ##1 !thermal_alert_out ##1 !thermal_alert_out)
    else $error("flag acted on before two sync stages");
  a_ack_one_cycle: assert property ( // bus handshake
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bad ack timing");
  a_dat_idle_zero: assert property ( // bus handshake
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  a_target_decode: assert property (
    still_r == 5'h1F |-> target_dmv == exp_dmv) else $error("target mismatch");
  c_crowbar: cover property (overvoltage_trip && driver_enable_n && pwm_out == 3'h0);
  c_reverse: cover property (reverse_voltage_trip && off_out);
  c_alert: cover property (thermal_alert_out && !thermal_sense_in);
endmodule
bind vfp_top vfp_props u_props (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .overvoltage_trip, .reverse_voltage_trip, .reverse_voltage_clear,
  .thermal_sense_in, .thermal_sense_release, .supply_lockout, .enable_in, .voltage_code,
  .pwm_out, .low_side_mode_n, .driver_enable_n, .soft_start_discharge,
  .power_good_delay_cap, .thermal_alert_out, .target_dmv);
`default_nettype wire

// ---- test/vfp_far_end.sv ----
// far side: phase drivers and the processor setting the code lines
// assumes one clock; the bench picks the code and whether it comes skewed
`timescale 1ns/100ps
`default_nettype none
module vfp_far_end (
  input wire logic clk_sys,
  input wire logic supply_lockout,
  input wire logic slow,
  input wire logic [6:0] code_req,
  input wire logic [2:0] pwm_out,
  input wire logic low_side_mode_n,
  input wire logic driver_enable_n,
  output logic [6:0] voltage_code,
  output logic lows_on,
  output logic all_off
);
  // ----
  // driver state and code lines
  // ----
  logic [6:0] diff;
  // low switches conduct only with both lines high and no phase pulsing
  assign lows_on = low_side_mode_n && driver_enable_n && pwm_out == 3'h0;
  assign all_off = !driver_enable_n && pwm_out == 3'h0;
  assign diff = voltage_code ^ code_req;
  initial voltage_code = 7'h00;
  // slow mode moves one line per clock, the skew the keep-out must ride out
  always @(posedge clk_sys) begin
    if (supply_lockout) begin
      voltage_code <= 7'h00;
    end else if (!slow) begin
      voltage_code <= code_req;
    end else begin
      voltage_code <= voltage_code ^ (diff & (~diff + 7'h01));
    end
  end
endmodule
`default_nettype wire

// ---- test/vfp_top_tb.sv ----
// self-checking bench of the protection block with its far-end model
// assumes design files, checker and far-end model compile first
`include "vfp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module vfp_top_tb;
  // ----
  // nets, pins packed as ov rvt rvc th thr lko en
  // ----
  logic clk_sys, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, slow, lows_on, all_off;
  wire logic overvoltage_trip, reverse_voltage_trip, reverse_voltage_clear;
  wire logic thermal_sense_in, thermal_sense_release, supply_lockout, enable_in;
  logic low_side_mode_n, driver_enable_n, soft_start_discharge, power_good_delay_cap;
  logic thermal_alert_out;
  logic [6:0] pin, voltage_code, code_req;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [2:0] pwm_req, pwm_out;
  logic [13:0] target_dmv;
  int num_errors, n_checks;
  assign {overvoltage_trip, reverse_voltage_trip, reverse_voltage_clear, thermal_sense_in,
    thermal_sense_release, supply_lockout, enable_in} = pin;
  vfp_top uut (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .overvoltage_trip, .reverse_voltage_trip,
    .reverse_voltage_clear, .thermal_sense_in, .thermal_sense_release, .supply_lockout,
    .enable_in, .voltage_code, .pwm_req, .pwm_out, .low_side_mode_n, .driver_enable_n,
    .soft_start_discharge, .power_good_delay_cap, .thermal_alert_out, .target_dmv);
  vfp_far_end u_far (.clk_sys, .supply_lockout, .slow, .code_req, .pwm_out,
    .low_side_mode_n, .driver_enable_n, .voltage_code, .lows_on, .all_off);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // watchdog, far beyond the roughly four hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic drv(input logic [4:0] e);
    chk("drive", {27'h0, e}, {27'h0, pwm_out, low_side_mode_n, driver_enable_n});
  endtask
  task automatic dis(input logic [1:0] e);
    chk("discharge", {30'h0, e}, {30'h0, soft_start_discharge, power_good_delay_cap});
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // pins are synchronised, so six cycles cover the three-cycle path
  task automatic step(input logic [6:0] v);
    @(posedge clk_sys);
    pin <= v;
    settle(6);
  endtask
  // classic single cycle, held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) chk("bus ack", 32'h1, 32'h0);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic t_regs;
    settle(1);
    drv(5'h00);
    dis(2'h3);
    wb(0, `VFP_ADDR_CTRL, 0);
    chk("ctrl", 32'h1, rdat);
    wb(0, `VFP_ADDR_IRQ_MASK, 0);
    chk("mask", 32'h0, rdat);
    wb(1, 8'h20, 32'hFF);
    wb(0, 8'h20, 0);
    chk("unmapped", 32'h0, rdat);
    wb(1, `VFP_ADDR_STATUS, 32'hFF);
    wb(0, `VFP_ADDR_STATUS, 0);
    chk("status", 32'h1, rdat & 32'hF);
  endtask
  task automatic t_run;
    step(7'h01);
    drv(5'h17);
    dis(2'h0);
    wb(1, `VFP_ADDR_CTRL, 32'h3);
    settle(2);
    drv(5'h15);
    wb(1, `VFP_ADDR_CTRL, 32'h1);
  endtask
  task automatic t_ov;
    step(7'h41);
    drv(5'h03);
    chk("lows on", 32'h1, {31'h0, lows_on});
    step(7'h01);
    drv(5'h03);
    step(7'h21);
    drv(5'h00);
    step(7'h01);
    drv(5'h00);
    step(7'h11);
    drv(5'h03);
    wb(0, `VFP_ADDR_IRQ_STAT, 0);
    chk("ov event", 32'h1, rdat & 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(1, `VFP_ADDR_IRQ_MASK, 32'h1);
    settle(2);
    chk("irq on", 32'h1, {31'h0, irq_o});
    wb(1, `VFP_ADDR_IRQ_STAT, 32'hF);
    settle(2);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    step(7'h10);
    drv(5'h00);
    step(7'h11);
    drv(5'h17);
    step(7'h41);
    drv(5'h03);
    step(7'h03);
    drv(5'h00);
    dis(2'h3);
    step(7'h01);
    drv(5'h17);
  endtask
  task automatic t_rev;
    step(7'h21);
    drv(5'h00);
    chk("all off", 32'h1, {31'h0, all_off});
    step(7'h01);
    drv(5'h00);
    step(7'h11);
    drv(5'h17);
  endtask
  task automatic t_shdn;
    step(7'h13);
    drv(5'h00);
    dis(2'h3);
    wb(0, `VFP_ADDR_STATUS, 0);
    chk("state", 32'h1, rdat & 32'hF);
    step(7'h11);
    drv(5'h17);
  endtask
  task automatic t_therm;
    step(7'h19);
    chk("alert", 32'h1, {31'h0, thermal_alert_out});
    step(7'h11);
    chk("alert held", 32'h1, {31'h0, thermal_alert_out});
    step(7'h15);
    chk("alert off", 32'h0, {31'h0, thermal_alert_out});
  endtask
  task automatic t_code;
    logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h40, 7'h77, 7'h78, 7'h7F};
    logic [13:0] e;
    foreach (codes[i]) begin
      @(posedge clk_sys);
      slow <= codes[i][0];
      code_req <= codes[i];
      settle(24);
      e = (codes[i] >= 7'h78) ? 14'h0 : 14'h3A98 - 14'h007D * {7'h0, codes[i]};
      chk("target", {18'h0, e}, {18'h0, target_dmv});
      wb(0, `VFP_ADDR_TARGET, 0);
      chk("target reg", {9'h0, codes[i], 2'h0, e}, rdat);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, slow} = 4'h0;
    pin = 7'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    code_req = 7'h00;
    pwm_req = 3'h5;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_run();
    t_ov();
    t_rev();
    t_shdn();
    t_therm();
    t_code();
    print_verdict();
  end
endmodule
`default_nettype wire
